/* hw/gpks_sequencer.v */
// Summary of operation
// - a completed low pulse of at least 1 s on the key powers the engine on.
// - the same pulse while on shuts down, starting only after release.
// - the key pad is pulled up outside this logic; the far party only pulls it low. The test's key host drives it both high and low.
// - the monitor rises at power-up; the far party waits 900 ms after it.
// - the monitor goes low once powered off, meaning the engine is off.
// - power on the charge input turns the engine fully on without a pulse.
// - software command or key pulse both lead to the same off state.
// - either shutdown path sends a network detach before powering off.
`timescale 1ns/1ps
`include "gpks_consts.vh"

module gpks_sequencer #(
    // hold time that counts as a press, in clock cycles (1 s at 50 MHz)
    parameter [`GPKS_CNT_W-1:0] KEY_MIN_CYC = `GPKS_KEY_MIN_CYC,
    // settle time after the monitor rises, in clock cycles (900 ms)
    parameter [`GPKS_CNT_W-1:0] READY_CYC = `GPKS_READY_CYC
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // power key pad, open collector, pulled up outside this logic
    input wire engine_power_key_n_i,
    // charging input supply present
    input wire charge_present_i,
    // software shutdown command, one-cycle pulse
    input wire sw_shutdown_i,
    // network detach handshake
    output wire detach_req_o,
    input wire detach_done_i,
    // power state
    output wire power_state_monitor_o,
    output wire engine_ready_o
);

// one-hot states
localparam [4:0] ST_OFF = 5'h01;
localparam [4:0] ST_ON = 5'h02;
localparam [4:0] ST_KEY_HELD = 5'h04;
localparam [4:0] ST_DETACH = 5'h08;
localparam [4:0] ST_WAIT_REL = 5'h10;

// sequencer state
reg [4:0] state_ff;
reg [4:0] nxt_state;

// output flops
reg mon_ff;
reg nxt_mon;
reg detach_ff;
reg nxt_detach;

// long press seen while off, waiting for release
reg key_armed_ff;
reg nxt_key_armed;

// charger history for edge detect
reg chg_prev_ff;

// decoded pad and timer status
wire key_low;
wire key_long;
wire ready_done;
wire chg_rise;

// pad reads low only when the far side pulls it; the pull-up is outside
// this logic, so an undriven pad simply arrives here as high
assign key_low = ~engine_power_key_n_i;

// key hold timer, cleared when the pad goes high; it saturates, so a
// press of any length above the minimum still counts as one press
gpks_timer u_key_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(key_low),
    .limit_i(KEY_MIN_CYC),
    .done_o(key_long)
);

// settle timer after the monitor rises; restarts on every power-up
// because it is cleared while the monitor is low
gpks_timer u_ready_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(mon_ff),
    .limit_i(READY_CYC),
    .done_o(ready_done)
);

// charger acts on its rising edge only, so a charger left plugged in
// does not keep powering the engine back on after a shutdown
assign chg_rise = charge_present_i & ~chg_prev_ff;

// state sequencing
// no detach timeout: if the network side never answers, the engine
// stays in the detach state with the monitor high and only a reset
// gets it out. key presses there are ignored on purpose so a user
// cannot cut the detach short.
always @* begin
    nxt_state = state_ff;
    nxt_mon = mon_ff;
    nxt_detach = 1'b0;
    nxt_key_armed = key_armed_ff;
    case (state_ff)
        // off: wait for a completed long press or a charger edge
        ST_OFF: begin
            if (chg_rise) begin
                nxt_state = ST_WAIT_REL;
                nxt_mon = 1'b1;
                nxt_key_armed = 1'b0;
            end else if (key_low && key_long) begin
                nxt_key_armed = 1'b1;
            end else if (!key_low && key_armed_ff) begin
                // power on only when the long pulse ends
                nxt_state = ST_ON;
                nxt_mon = 1'b1;
                nxt_key_armed = 1'b0;
            end else if (!key_low) begin
                nxt_key_armed = 1'b0;
            end
        end
        // on: watch for software command or a long press
        ST_ON: begin
            if (sw_shutdown_i) begin
                nxt_state = ST_DETACH;
                nxt_detach = 1'b1;
            end else if (key_low && key_long) begin
                nxt_state = ST_KEY_HELD;
            end
        end
        ST_KEY_HELD: begin
            // key shutdown waits for the release; a software command goes at once
            if (sw_shutdown_i || !key_low) begin
                nxt_state = ST_DETACH;
                nxt_detach = 1'b1;
            end
        end
        // detach: hold the request until the network side answers
        ST_DETACH: begin
            if (detach_done_i) begin
                nxt_state = ST_OFF;
                nxt_mon = 1'b0;
                nxt_key_armed = 1'b0;
            end else begin
                nxt_detach = 1'b1;
            end
        end
        ST_WAIT_REL: begin
            // powered by charger; a key held meanwhile must not count
            // software wins over the release so a command in the
            // release cycle is never lost
            if (sw_shutdown_i) begin
                nxt_state = ST_DETACH;
                nxt_detach = 1'b1;
            end else if (!key_low) begin
                nxt_state = ST_ON;
            end
        end
        // illegal code: fall back to off with the monitor low
        default: begin
            nxt_state = ST_OFF;
            nxt_mon = 1'b0;
            nxt_key_armed = 1'b0;
        end
    endcase
end

// state register; only constants on the async branch
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        state_ff <= ST_OFF;
    end else begin
        state_ff <= nxt_state;
    end
end

// monitor flop; straight from a flop so the far side never sees a glitch
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        mon_ff <= `GPKS_RST_MON;
    end else begin
        mon_ff <= nxt_mon;
    end
end

// detach request flop, held until the network side answers
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        detach_ff <= 1'b0;
    end else begin
        detach_ff <= nxt_detach;
    end
end

// armed flag: set once a held key passes the minimum, cleared on release
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        key_armed_ff <= 1'b0;
    end else begin
        key_armed_ff <= nxt_key_armed;
    end
end

// charger sample; reset low, so a charger already present when reset
// ends is seen as a rising edge and powers the engine on
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        chg_prev_ff <= 1'b0;
    end else begin
        chg_prev_ff <= charge_present_i;
    end
end

// outputs; all from flops except ready, the and of the monitor flop and the settle timer's limit compare
assign power_state_monitor_o = mon_ff;
assign detach_req_o = detach_ff;
assign engine_ready_o = mon_ff & ready_done;

endmodule // gpks_sequencer

/* hw/gpks_consts.vh */
`ifndef GPKS_CONSTS_VH
`define GPKS_CONSTS_VH

// clock rate and timing figures
// sized to the counter so they meet the timer limit with no padding
`define GPKS_KEY_MIN_CYC 26'h2faf080
`define GPKS_READY_CYC 26'h2aea540
`define GPKS_CNT_W 26

// reset values
`define GPKS_RST_MON 1'b0

`endif

/* hw/gpks_timer.v */
`timescale 1ns/1ps
`include "gpks_consts.vh"

// counts cycles while run_i is high, flags reaching the limit
module gpks_timer (
    // clock and reset
    input wire core_clk_i,
    input wire rst_i,
    // control
    input wire run_i,
    input wire [`GPKS_CNT_W-1:0] limit_i,
    // status
    output wire done_o
);

reg [`GPKS_CNT_W-1:0] cnt_ff;
wire [`GPKS_CNT_W-1:0] nxt_cnt;

// saturates at the limit so a long hold cannot wrap back to short
assign done_o = (cnt_ff >= limit_i);
assign nxt_cnt = !run_i ? {`GPKS_CNT_W{1'b0}} :
                 done_o ? cnt_ff : cnt_ff + 1'b1;

always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        cnt_ff <= {`GPKS_CNT_W{1'b0}};
    end else begin
        cnt_ff <= nxt_cnt;
    end
end

endmodule // gpks_timer

/* sim/gpks_key_host.sv */
`timescale 1ns/1ps
// far side: host driving the key pad both high and low
module gpks_key_host (
    // control
    input wire press_i,
    // pad
    output wire engine_power_key_n_o
);
    // driven high on release and low on press, no pull-up needed
    assign engine_power_key_n_o = !press_i;
endmodule // gpks_key_host

/* sim/gpks_sequencer_properties.sv */
`timescale 1ns/1ps
module gpks_chk (
    // clock, reset
    input wire core_clk_i,
    input wire rst_i,
    // watched pins
    input wire engine_power_key_n_i,
    input wire charge_present_i,
    input wire sw_shutdown_i,
    input wire detach_done_i,
    input wire detach_req_o,
    input wire power_state_monitor_o,
    input wire engine_ready_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    property p_chg; $rose(charge_present_i) && engine_power_key_n_i &&
        !power_state_monitor_o |-> ##[1:4] power_state_monitor_o; endproperty
    a_chg: assert property (p_chg) else $error("chg");
    property p_off; detach_req_o && detach_done_i
        |=> !power_state_monitor_o && !detach_req_o; endproperty
    a_off: assert property (p_off) else $error("off");
    property p_hold; detach_req_o && !detach_done_i |=> detach_req_o;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_fall; $fell(power_state_monitor_o) |-> $past(detach_req_o);
    endproperty
    a_fall: assert property (p_fall) else $error("fall");
    property p_sw; sw_shutdown_i && power_state_monitor_o && !detach_req_o
        |=> detach_req_o; endproperty
    a_sw: assert property (p_sw) else $error("sw");
    property p_held; !engine_power_key_n_i && !sw_shutdown_i &&
        !detach_req_o |=> !detach_req_o; endproperty
    a_held: assert property (p_held) else $error("held");
    property p_rdy; engine_ready_o |-> power_state_monitor_o; endproperty
    a_rdy: assert property (p_rdy) else $error("rdy");
    property p_rise; $rose(power_state_monitor_o) |-> !engine_ready_o &&
        ($past(engine_power_key_n_i) || ($past(charge_present_i) &&
        !$past(charge_present_i, 2))); endproperty
    a_rise: assert property (p_rise) else $error("rise");
endmodule // gpks_chk
bind gpks_sequencer gpks_chk gpks_chk_i (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .engine_power_key_n_i(engine_power_key_n_i),
    .charge_present_i(charge_present_i), .sw_shutdown_i(sw_shutdown_i),
    .detach_done_i(detach_done_i), .detach_req_o(detach_req_o),
    .power_state_monitor_o(power_state_monitor_o),
    .engine_ready_o(engine_ready_o));

/* sim/gpks_sequencer_test.sv */
`timescale 1ns/1ps
module gpks_sequencer_test;
    reg clk = 1'b0, rst = 1'b1, press = 1'b0, chg = 1'b0;
    reg sw = 1'b0, done = 1'b0;
    wire key_n, req, mon, rdy;
    integer errors = 0, num_checks = 0, n;
    gpks_key_host gpks_key_host_i (.press_i(press),
        .engine_power_key_n_o(key_n));
    gpks_sequencer #(.KEY_MIN_CYC(26'h28), .READY_CYC(26'h1e))
        gpks_sequencer_i (.core_clk_i(clk), .rst_i(rst),
        .engine_power_key_n_i(key_n), .charge_present_i(chg),
        .sw_shutdown_i(sw), .detach_req_o(req), .detach_done_i(done),
        .power_state_monitor_o(mon), .engine_ready_o(rdy));
    // 50 MHz; key and settle times shortened to 40 and 30 cycles
    initial forever #10 clk = ~clk;
    task tick(input integer c); repeat (c) @(posedge clk); #1; endtask
    task check(input string nm, input logic exp, input logic got);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %s exp %b got %b", nm, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // press for c cycles, release, expect monitor m and detach r
    task t_key(input integer c, input logic m, input logic r);
        @(posedge clk) press <= 1'b1;
        tick(c);
        check("req", 1'b0, req);
        @(posedge clk) press <= 1'b0;
        tick(5);
        check("mon", m, mon);
        check("req", r, req);
        $display("key test done");
    endtask
    // ready only after the settle time
    task t_rdy;
        check("rdy", 1'b0, rdy);
        tick(30);
        check("rdy", 1'b1, rdy);
        check("mon", 1'b1, mon);
        $display("ready test done");
    endtask
    // network answers the detach, monitor then drops
    task t_done;
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        tick(1);
        check("mon", 1'b0, mon);
        check("req", 1'b0, req);
    endtask
    // charger rise powers on; with key held, software off still acts
    task t_chg(input logic hold);
        @(posedge clk) begin
            chg <= 1'b0;
            press <= hold;
        end
        @(posedge clk) chg <= 1'b1;
        for (n = 0; n < 8 && mon !== 1'b1; n = n + 1) tick(1);
        check("mon", 1'b1, mon);
        check("rdy", 1'b0, rdy);
        if (hold) begin
            @(posedge clk) sw <= 1'b1;
            @(posedge clk) begin
                sw <= 1'b0;
                press <= 1'b0;
            end
            tick(2);
            check("req", 1'b1, req);
            t_done;
        end
        $display("charge test done");
    endtask
    // software off: detach held until done when on, none when off; then monitor low
    task t_sw(input logic on);
        @(posedge clk) sw <= 1'b1;
        @(posedge clk) sw <= 1'b0;
        tick(20);
        check("req", on, req);
        t_done;
        $display("sw test done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        check("mon", 1'b0, mon);
        t_key(10, 1'b0, 1'b0);
        t_key(60, 1'b1, 1'b0);
        t_rdy;
        t_key(10, 1'b1, 1'b0);
        t_key(60, 1'b1, 1'b1);
        t_done;
        t_sw(1'b0);
        t_chg(1'b1);
        t_chg(1'b0);
        t_sw(1'b1);
        close_out;
    end
endmodule // gpks_sequencer_test
